/* verilog/sfp_mgmt_consts.svh */
// offsets, field positions and timing counts of the module management port
`ifndef SFP_MGMT_CONSTS_SVH
`define SFP_MGMT_CONSTS_SVH
`define ID_DEV_ADDR 7'h50
`define DIAG_DEV_ADDR 7'h51
`define BYTE_LAST_BIT 3'h7
`define DIAG_USER_BASE 8'h80
`define DIAG_LIVE_BASE 8'h60
`define DIAG_LIVE_LAST 8'h69
`define ALARM_FLAGS_HI 8'h70
`define ALARM_FLAGS_LO 8'h71
`define WARN_FLAGS_HI 8'h74
`define WARN_FLAGS_LO 8'h75
`define LIMIT_BYTES 8
`define MON_COUNT 5
`define FLAG_COUNT 10
`define REG_AREA_ID 2'h0
`define REG_AREA_DIAG 2'h1
`define REG_AREA_CTRL 2'h2
`define REG_STATUS 8'h00
`define REG_MASK 8'h01
`define REG_CTRL 8'h02
`define REG_PINS 8'h03
`define CTRL_MON_EN 0
`define CTRL_TX_FORCE_OFF 1
`define EV_ALARM 0
`define EV_WARN 1
`define EV_SIG_LOST 2
`define EV_TX_FAULT 3
`define EV_HOST_WRITE 4
`define EV_TX_DISABLE 5
`define EV_COUNT 6
`define PIN_SCL 0
`define PIN_SDA 1
`define PIN_TXDIS 2
`define PIN_RXSIG 3
`define PIN_LFAULT 4
`define PIN_LASERON 5
`define PIN_COUNT 6
`define PIN_RESET_VAL 6'h07
`define CLK_PERIOD_NS 40
`define TX_OFF_MAX_NS 10000
`define TX_OFF_CYCLES (`TX_OFF_MAX_NS / `CLK_PERIOD_NS)
`define TX_OFF_CNT_W 8
`endif

/* verilog/sfp_mgmt_pkg.sv */
// types shared by the module management port
package sfp_mgmt_pkg;
    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] supply;
        logic [15:0] biasCurrent;
        logic [15:0] txPower;
        logic [15:0] rxPower;
    } monitor_t;

    typedef struct packed {
        logic [15:0] hiAlarm;
        logic [15:0] loAlarm;
        logic [15:0] hiWarn;
        logic [15:0] loWarn;
    } limits_t;

    typedef struct packed {
        logic hiAlarm;
        logic loAlarm;
        logic hiWarn;
        logic loWarn;
    } limit_flags_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_WORD_ADDR,
        ST_WRITE,
        ST_ACK,
        ST_READ,
        ST_HOST_ACK
    } mgmt_state_t;
endpackage : sfp_mgmt_pkg

/* verilog/pin_sync.sv */
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pinAsync,
    output logic [WIDTH-1:0] pinSynced
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta <= RESET_VAL;
            pinSynced <= RESET_VAL;
        end else begin
            meta <= pinAsync;
            pinSynced <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

/* verilog/limit_check.sv */
// compares one monitored reading against its four limits
`timescale 1ns/1ps
`default_nettype none
module limit_check (
    input wire logic [15:0] value,
    input wire sfp_mgmt_pkg::limits_t limits,
    output sfp_mgmt_pkg::limit_flags_t flags
);
    // unsigned compare: signed readings need biased limits
    always_comb begin
        flags.hiAlarm = value > limits.hiAlarm;
        flags.loAlarm = value < limits.loAlarm;
        flags.hiWarn = value > limits.hiWarn;
        flags.loWarn = value < limits.loWarn;
    end
endmodule : limit_check
`default_nettype wire

/* verilog/sfp_mgmt_port.sv */
// management side of a pluggable transceiver: serial target, diagnostics, status pins
`include "sfp_mgmt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sfp_mgmt_port (
    input wire logic clk,
    input wire logic rstn,
    input wire logic mgmtClockPin,
    input wire logic mgmtDataIn,
    output logic mgmtDataOut,
    output logic mgmtDataOe,
    output logic presencePinOut,
    output logic presencePinOe,
    input wire logic txDisablePin,
    input wire logic rxSignalDetect,
    input wire logic laserFaultIn,
    input wire logic laserOnSense,
    input wire sfp_mgmt_pkg::monitor_t monitor,
    output logic txEnable,
    output logic rxSignalLost,
    output logic rxDataEnable,
    output logic laserFault,
    input wire logic [9:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output logic irq
);
    logic [`PIN_COUNT-1:0] pinRaw;
    logic [`PIN_COUNT-1:0] pinSync;
    logic sclNow, sdaNow, sclPrev, sdaPrev;
    logic sclRise, sclFall, startCond, stopCond;
    sfp_mgmt_pkg::mgmt_state_t state, afterAck;
    logic [2:0] bitCnt;
    logic [7:0] rxShift, txShift, wordPtr, hostWrAddr, hostWrData;
    logic diagSel, hostAck, sdaOe, hostWrite;
    logic [7:0] idMem [256];
    logic [7:0] diagMem [256];
    logic [15:0] liveSnap [`MON_COUNT];
    logic [15:0] reading [`MON_COUNT];
    logic [`FLAG_COUNT-1:0] alarmNow, warnNow, alarmFlags, warnFlags;
    logic [`EV_COUNT-1:0] statusReg, statusNext, maskReg, events;
    logic monEnable, txForceOff, laserStuck;
    logic [`TX_OFF_CNT_W-1:0] offCnt;
    logic [79:0] monFlat;
    logic [1:0] regArea;
    logic [7:0] regIndex;
    logic [7:0] memByte;

    assign pinRaw = {laserOnSense, laserFaultIn, rxSignalDetect, txDisablePin,
                     mgmtDataIn, mgmtClockPin};

    // clock line is only ever an input here
    pin_sync #(.WIDTH(`PIN_COUNT), .RESET_VAL(`PIN_RESET_VAL)) u_pins (
        .clk(clk),
        .rstn(rstn),
        .pinAsync(pinRaw),
        .pinSynced(pinSync)
    );

    assign sclNow = pinSync[`PIN_SCL];
    assign sdaNow = pinSync[`PIN_SDA];
    assign regArea = regAddr[9:8];
    assign regIndex = regAddr[7:0];
    assign monFlat = monitor;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclNow;
            sdaPrev <= sdaNow;
        end
    end

    assign sclRise = sclNow & ~sclPrev;
    assign sclFall = ~sclNow & sclPrev;
    assign startCond = sclNow & sclPrev & sdaPrev & ~sdaNow;
    assign stopCond = sclNow & sclPrev & ~sdaPrev & sdaNow;

    // one read path serves both the serial target and the register port
    function automatic logic [7:0] memRead(input logic sel, input logic [7:0] addr);
        logic [7:0] off;
        logic [15:0] word;
        off = addr - `DIAG_LIVE_BASE;
        word = liveSnap[off[3:1]];
        if (!sel) begin
            memRead = idMem[addr];
        end else if (addr >= `DIAG_LIVE_BASE && addr <= `DIAG_LIVE_LAST) begin
            memRead = off[0] ? word[7:0] : word[15:8];
        end else if (addr == `ALARM_FLAGS_HI) begin
            memRead = alarmFlags[`FLAG_COUNT-1:2];
        end else if (addr == `ALARM_FLAGS_LO) begin
            memRead = {alarmFlags[1:0], 6'h00};
        end else if (addr == `WARN_FLAGS_HI) begin
            memRead = warnFlags[`FLAG_COUNT-1:2];
        end else if (addr == `WARN_FLAGS_LO) begin
            memRead = {warnFlags[1:0], 6'h00};
        end else begin
            memRead = diagMem[addr];
        end
    endfunction : memRead

    assign memByte = memRead(diagSel, wordPtr);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxShift <= 8'h00;
            hostAck <= 1'b0;
        end else if (sclRise) begin
            rxShift <= {rxShift[6:0], sdaNow};
            hostAck <= ~sdaNow;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= sfp_mgmt_pkg::ST_IDLE;
            afterAck <= sfp_mgmt_pkg::ST_IDLE;
            bitCnt <= 3'h0;
            wordPtr <= 8'h00;
            diagSel <= 1'b0;
            txShift <= 8'h00;
            sdaOe <= 1'b0;
            hostWrite <= 1'b0;
            hostWrAddr <= 8'h00;
            hostWrData <= 8'h00;
        end else begin
            hostWrite <= 1'b0;
            if (stopCond) begin
                state <= sfp_mgmt_pkg::ST_IDLE;
                sdaOe <= 1'b0;
            end else if (startCond) begin
                // park until the start's own clock fall so it is not counted as a bit
                state <= sfp_mgmt_pkg::ST_ACK;
                afterAck <= sfp_mgmt_pkg::ST_DEV_ADDR;
                bitCnt <= 3'h0;
                sdaOe <= 1'b0;
            end else if (sclFall) begin
                case (state)
                    sfp_mgmt_pkg::ST_DEV_ADDR: begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == `BYTE_LAST_BIT) begin
                            if (rxShift[7:1] == `ID_DEV_ADDR ||
                                rxShift[7:1] == `DIAG_DEV_ADDR) begin
                                diagSel <= (rxShift[7:1] == `DIAG_DEV_ADDR);
                                afterAck <= rxShift[0] ? sfp_mgmt_pkg::ST_READ
                                                       : sfp_mgmt_pkg::ST_WORD_ADDR;
                                state <= sfp_mgmt_pkg::ST_ACK;
                                sdaOe <= 1'b1;
                            end else begin
                                state <= sfp_mgmt_pkg::ST_IDLE;
                            end
                        end
                    end
                    sfp_mgmt_pkg::ST_WORD_ADDR: begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == `BYTE_LAST_BIT) begin
                            wordPtr <= rxShift;
                            afterAck <= sfp_mgmt_pkg::ST_WRITE;
                            state <= sfp_mgmt_pkg::ST_ACK;
                            sdaOe <= 1'b1;
                        end
                    end
                    sfp_mgmt_pkg::ST_WRITE: begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == `BYTE_LAST_BIT) begin
                            // protected bytes are acknowledged but not stored
                            hostWrite <= diagSel && (wordPtr >= `DIAG_USER_BASE);
                            hostWrAddr <= wordPtr;
                            hostWrData <= rxShift;
                            wordPtr <= wordPtr + 8'h01;
                            afterAck <= sfp_mgmt_pkg::ST_WRITE;
                            state <= sfp_mgmt_pkg::ST_ACK;
                            sdaOe <= 1'b1;
                        end
                    end
                    sfp_mgmt_pkg::ST_ACK: begin
                        bitCnt <= 3'h0;
                        state <= afterAck;
                        if (afterAck == sfp_mgmt_pkg::ST_READ) begin
                            txShift <= memByte;
                            sdaOe <= ~memByte[7];
                        end else begin
                            sdaOe <= 1'b0;
                        end
                    end
                    sfp_mgmt_pkg::ST_READ: begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == `BYTE_LAST_BIT) begin
                            sdaOe <= 1'b0;
                            wordPtr <= wordPtr + 8'h01;
                            state <= sfp_mgmt_pkg::ST_HOST_ACK;
                        end else begin
                            txShift <= {txShift[6:0], 1'b0};
                            sdaOe <= ~txShift[6];
                        end
                    end
                    sfp_mgmt_pkg::ST_HOST_ACK: begin
                        bitCnt <= 3'h0;
                        if (hostAck) begin
                            txShift <= memByte;
                            sdaOe <= ~memByte[7];
                            state <= sfp_mgmt_pkg::ST_READ;
                        end else begin
                            state <= sfp_mgmt_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open drain: the line is only ever pulled low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mgmtDataOut <= 1'b0;
            mgmtDataOe <= 1'b0;
        end else begin
            mgmtDataOut <= 1'b0;
            mgmtDataOe <= sdaOe;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 256; i++) begin
                idMem[i] <= 8'h00;
            end
        end else if (regWr && regArea == `REG_AREA_ID) begin
            idMem[regIndex] <= regWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 256; i++) begin
                diagMem[i] <= 8'h00;
            end
        end else if (hostWrite) begin
            diagMem[hostWrAddr] <= hostWrData;
        end else if (regWr && regArea == `REG_AREA_DIAG) begin
            diagMem[regIndex] <= regWrData;
        end
    end

    // frozen while a serial transaction runs so multi-byte readings never tear within one serial read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < `MON_COUNT; i++) begin
                liveSnap[i] <= 16'h0000;
            end
        end else if (state == sfp_mgmt_pkg::ST_IDLE) begin
            for (int i = 0; i < `MON_COUNT; i++) begin
                liveSnap[i] <= reading[i];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `MON_COUNT; gi++) begin : g_mon
            sfp_mgmt_pkg::limits_t lim;
            sfp_mgmt_pkg::limit_flags_t flags;
            assign reading[gi] = monFlat[(`MON_COUNT-1-gi)*16 +: 16];
            assign lim = {diagMem[gi*`LIMIT_BYTES], diagMem[gi*`LIMIT_BYTES+1],
                          diagMem[gi*`LIMIT_BYTES+2], diagMem[gi*`LIMIT_BYTES+3],
                          diagMem[gi*`LIMIT_BYTES+4], diagMem[gi*`LIMIT_BYTES+5],
                          diagMem[gi*`LIMIT_BYTES+6], diagMem[gi*`LIMIT_BYTES+7]};
            limit_check u_chk (
                .value(reading[gi]),
                .limits(lim),
                .flags(flags)
            );
            assign alarmNow[2*(`MON_COUNT-1-gi)+1] = flags.hiAlarm;
            assign alarmNow[2*(`MON_COUNT-1-gi)] = flags.loAlarm;
            assign warnNow[2*(`MON_COUNT-1-gi)+1] = flags.hiWarn;
            assign warnNow[2*(`MON_COUNT-1-gi)] = flags.loWarn;
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            alarmFlags <= '0;
            warnFlags <= '0;
        end else begin
            alarmFlags <= monEnable ? alarmNow : '0;
            warnFlags <= monEnable ? warnNow : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            txEnable <= 1'b0;
            rxSignalLost <= 1'b1;
            rxDataEnable <= 1'b0;
            presencePinOut <= 1'b0;
            presencePinOe <= 1'b1;
        end else begin
            // synchroniser resets high, so the laser stays off until the pin's value has passed both flops
            txEnable <= ~(pinSync[`PIN_TXDIS] | txForceOff);
            rxSignalLost <= ~pinSync[`PIN_RXSIG];
            rxDataEnable <= pinSync[`PIN_RXSIG];
            presencePinOut <= 1'b0;
            presencePinOe <= 1'b1;
        end
    end

    // light still sensed long after disable counts as a laser fault
    always_ff @(posedge clk) begin
        if (!rstn) begin
            offCnt <= '0;
            laserStuck <= 1'b0;
            laserFault <= 1'b0;
        end else begin
            if (txEnable || !pinSync[`PIN_LASERON]) begin
                offCnt <= '0;
                laserStuck <= 1'b0;
            end else if (offCnt == `TX_OFF_CNT_W'(`TX_OFF_CYCLES)) begin
                laserStuck <= 1'b1;
            end else begin
                offCnt <= offCnt + `TX_OFF_CNT_W'(1);
            end
            laserFault <= pinSync[`PIN_LFAULT] | laserStuck;
        end
    end

    always_comb begin
        events = '0;
        events[`EV_ALARM] = |(alarmNow & ~alarmFlags) & monEnable;
        events[`EV_WARN] = |(warnNow & ~warnFlags) & monEnable;
        events[`EV_SIG_LOST] = ~pinSync[`PIN_RXSIG] & ~rxSignalLost;
        events[`EV_TX_FAULT] = (pinSync[`PIN_LFAULT] | laserStuck) & ~laserFault;
        events[`EV_HOST_WRITE] = hostWrite;
        events[`EV_TX_DISABLE] = pinSync[`PIN_TXDIS] & txEnable;
        statusNext = statusReg;
        if (regWr && regArea == `REG_AREA_CTRL && regIndex == `REG_STATUS) begin
            statusNext = statusReg & ~regWrData[`EV_COUNT-1:0];
        end
        // a new event wins over a clear in the same cycle
        statusNext = statusNext | events;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            statusReg <= '0;
            maskReg <= '0;
            monEnable <= 1'b0;
            txForceOff <= 1'b0;
            irq <= 1'b0;
        end else begin
            statusReg <= statusNext;
            irq <= |(statusNext & maskReg);
            if (regWr && regArea == `REG_AREA_CTRL && regIndex == `REG_MASK) begin
                maskReg <= regWrData[`EV_COUNT-1:0];
            end
            if (regWr && regArea == `REG_AREA_CTRL && regIndex == `REG_CTRL) begin
                monEnable <= regWrData[`CTRL_MON_EN];
                txForceOff <= regWrData[`CTRL_TX_FORCE_OFF];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (!regRd) begin
            regRdData <= 8'h00;
        end else begin
            case (regArea)
                `REG_AREA_ID: regRdData <= memRead(1'b0, regIndex);
                `REG_AREA_DIAG: regRdData <= memRead(1'b1, regIndex);
                `REG_AREA_CTRL: begin
                    case (regIndex)
                        `REG_STATUS: regRdData <= {2'h0, statusReg};
                        `REG_MASK: regRdData <= {2'h0, maskReg};
                        `REG_CTRL: regRdData <= {6'h00, txForceOff, monEnable};
                        `REG_PINS: regRdData <= {3'h0, mgmtDataOe, laserFault,
                                                 rxSignalLost, txEnable, irq};
                        default: regRdData <= 8'h00;
                    endcase
                end
                default: regRdData <= 8'h00;
            endcase
        end
    end
endmodule : sfp_mgmt_port
`default_nettype wire

/* bench/sfp_mgmt_port_assertions.sv */
// pin-level assertions for the module management port
`timescale 1ns/1ps
`default_nettype none
module sfp_mgmt_port_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic mgmtClockPin,
    input wire logic mgmtDataOut,
    input wire logic mgmtDataOe,
    input wire logic presencePinOut,
    input wire logic presencePinOe,
    input wire logic txDisablePin,
    input wire logic rxSignalDetect,
    input wire logic laserFaultIn,
    input wire logic txEnable,
    input wire logic rxSignalLost,
    input wire logic rxDataEnable,
    input wire logic laserFault
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    presence_held_a: assert property (presencePinOe && !presencePinOut)
        else $error("presence pin not low");
    rx_gate_a: assert property (rxDataEnable == !rxSignalLost)
        else $error("rx data enable wrong");
    los_set_a: assert property (!rxSignalDetect [*4] |=> rxSignalLost)
        else $error("loss of signal not set");
    los_clear_a: assert property (rxSignalDetect [*4] |=> !rxSignalLost)
        else $error("loss of signal not cleared");
    tx_off_a: assert property (txDisablePin [*4] |=> !txEnable)
        else $error("transmitter still on");
    fault_out_a: assert property (laserFaultIn [*4] |=> laserFault)
        else $error("laser fault not shown");
    // clock falls reach the logic two flops late, hence the look back
    sda_edge_a: assert property ($changed(mgmtDataOe) |-> !$past(mgmtClockPin, 2))
        else $error("data changed with clock high");
    sda_pull_only_a: assert property (!mgmtDataOut)
        else $error("data line driven high");
    cover property ($rose(mgmtDataOe));
    cover property ($rose(laserFault));
    cover property ($fell(txEnable));
endmodule : sfp_mgmt_port_assertions
`default_nettype wire

/* bench/sfp_host_model.sv */
// two-wire bus master standing in for the host board
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
    input wire logic sdaWire,
    output logic scl,
    output logic sdaPull
);
    // clock rests high outside frames
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // data moves 40 ns after the fall so it never races the clock edge
    task automatic clockBit(input logic drive, input logic b, output logic seen);
        #40 sdaPull = drive && !b;
        #160 scl = 1'b1;
        #60 seen = sdaWire;
        #60 scl = 1'b0;
    endtask : clockBit
    task automatic start();
        #40 sdaPull = 1'b0;
        #160 scl = 1'b1;
        #60 sdaPull = 1'b1;
        #60 scl = 1'b0;
    endtask : start
    task automatic stop();
        #40 sdaPull = 1'b1;
        #160 scl = 1'b1;
        #60 sdaPull = 1'b0;
        #120;
    endtask : stop
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) clockBit(1'b1, d[i], x);
        clockBit(1'b0, 1'b0, x);
        ack = !x;
    endtask : sendByte
    task automatic getByte(input logic more, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) clockBit(1'b0, 1'b0, d[i]);
        clockBit(1'b1, !more, x);
    endtask : getByte
endmodule : sfp_host_model
`default_nettype wire

/* bench/sfp_mgmt_port_tb.sv */
// self-checking bench for the module management port
`timescale 1ns/1ps
`default_nettype none
module sfp_mgmt_port_tb;
    typedef struct packed {
        logic txd;
        logic rxd;
        logic flt;
        logic [2:0] exp;
    } pin_case_t;
    pin_case_t rows [4] = '{6'h14, 6'h06, 6'h39, 6'h14};
    logic clk = 1'b0;
    logic rstn, scl, sdaPull, sdaWire, dataOut, dataOe, presOut, presOe, irq;
    logic txDisablePin, rxSignalDetect, laserFaultIn, laserOnSense, regWr, regRd;
    logic txEnable, rxSignalLost, rxDataEnable, laserFault;
    logic [2:0] outs;
    logic [9:0] regAddr;
    logic [7:0] regWrData, regRdData;
    sfp_mgmt_pkg::monitor_t monitor;
    int err_count = 0;
    int cmp_count = 0;
    always #20 clk = ~clk;
    assign sdaWire = !(dataOe || sdaPull);
    assign outs = {txEnable, rxSignalLost, laserFault};
    sfp_mgmt_port uut (
        .clk(clk), .rstn(rstn), .mgmtClockPin(scl), .mgmtDataIn(sdaWire),
        .mgmtDataOut(dataOut), .mgmtDataOe(dataOe), .presencePinOut(presOut),
        .presencePinOe(presOe), .txDisablePin(txDisablePin), .rxSignalDetect(rxSignalDetect),
        .laserFaultIn(laserFaultIn), .laserOnSense(laserOnSense), .monitor(monitor),
        .txEnable(txEnable), .rxSignalLost(rxSignalLost), .rxDataEnable(rxDataEnable),
        .laserFault(laserFault), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .irq(irq)
    );
    sfp_host_model host (.sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic regWrite(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 check($sformatf("reg %h", a), exp, regRdData);
    endtask : regRead
    task automatic irqAfter(input logic [9:0] a, input logic [7:0] d, input logic exp);
        regWrite(a, d);
        repeat (2) @(posedge clk);
        #1 check("irq", {7'h0, exp}, {7'h0, irq});
    endtask : irqAfter
    task automatic put(input logic [7:0] d, input logic expAck);
        logic ack;
        host.sendByte(d, ack);
        check("ack", {7'h0, expAck}, {7'h0, ack});
    endtask : put
    task automatic frame(input logic [7:0] dev, input logic [7:0] word, input logic expAck);
        host.start();
        put(dev, expAck);
        if (expAck) put(word, 1'b1);
    endtask : frame
    task automatic readBack(input logic [7:0] dev, input logic [7:0] word, input logic [15:0] e);
        logic [7:0] d;
        frame(dev, word, 1'b1);
        host.start();
        put(dev | 8'h01, 1'b1);
        host.getByte(1'b1, d);
        check("serial byte", e[15:8], d);
        host.getByte(1'b0, d);
        check("serial byte", e[7:0], d);
        host.stop();
    endtask : readBack
    task automatic conclude();
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    initial begin
        rstn = 1'b0;
        regAddr = 10'h000;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        txDisablePin = 1'b1;
        rxSignalDetect = 1'b0;
        laserFaultIn = 1'b0;
        laserOnSense = 1'b0;
        monitor = {16'h1234, 64'h0};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        regRead(10'h203, 8'h04);
        foreach (rows[i]) begin
            @(posedge clk);
            txDisablePin <= rows[i].txd;
            rxSignalDetect <= rows[i].rxd;
            laserFaultIn <= rows[i].flt;
            repeat (5) @(posedge clk);
            #1 check("pins", {5'h0, rows[i].exp}, {5'h0, outs});
        end
        irqAfter(10'h200, 8'h3f, 1'b0);
        irqAfter(10'h201, 8'h04, 1'b0);
        @(posedge clk);
        rxSignalDetect <= 1'b0;
        repeat (6) @(posedge clk);
        regRead(10'h200, 8'h04);
        check("irq", 8'h01, {7'h0, irq});
        irqAfter(10'h201, 8'h00, 1'b0);
        irqAfter(10'h201, 8'h04, 1'b1);
        irqAfter(10'h200, 8'h04, 1'b0);
        regWrite(10'h3ff, 8'hff);
        regRead(10'h3ff, 8'h00);
        regWrite(10'h100, 8'h10);
        regWrite(10'h202, 8'h01);
        repeat (3) @(posedge clk);
        regRead(10'h170, 8'h80);
        @(posedge clk);
        #11;
        frame(8'ha2, 8'h80, 1'b1);
        put(8'h5a, 1'b1);
        put(8'ha5, 1'b1);
        host.stop();
        readBack(8'ha2, 8'h80, 16'h5aa5);
        readBack(8'ha2, 8'h60, 16'h1234);
        frame(8'ha0, 8'h10, 1'b1);
        put(8'h77, 1'b1);
        host.stop();
        readBack(8'ha0, 8'h10, 16'h0000);
        frame(8'ha4, 8'h00, 1'b0);
        host.stop();
        @(posedge clk);
        txDisablePin <= 1'b1;
        laserOnSense <= 1'b1;
        repeat (240) @(posedge clk);
        #1 check("fault early", 8'h00, {7'h0, laserFault});
        repeat (25) @(posedge clk);
        #1 check("fault late", 8'h01, {7'h0, laserFault});
        conclude();
    end
endmodule : sfp_mgmt_port_tb
bind sfp_mgmt_port sfp_mgmt_port_assertions chk (
    .clk(clk), .rstn(rstn), .mgmtClockPin(mgmtClockPin), .mgmtDataOut(mgmtDataOut),
    .mgmtDataOe(mgmtDataOe), .presencePinOut(presencePinOut), .presencePinOe(presencePinOe),
    .txDisablePin(txDisablePin), .rxSignalDetect(rxSignalDetect), .laserFaultIn(laserFaultIn),
    .txEnable(txEnable), .rxSignalLost(rxSignalLost), .rxDataEnable(rxDataEnable),
    .laserFault(laserFault)
);
`default_nettype wire
